// File: common/efi_pkg.sv
// package for the e1 framer event flag and enable block
// assumes an axi4-lite master with 32-bit data and 16-bit byte addresses
package efi_pkg;

    // ==========================================================
    // register indices and byte addresses (byte = index * 4)
    localparam int unsigned EFI_CTL_IDX = 32'h0000010B;
    localparam int unsigned EFI_FLAGS_IDX = 32'h00000B04;
    localparam int unsigned EFI_ENABLE_IDX = 32'h00000B05;
    localparam int unsigned EFI_ADDR_W = 16;
    localparam logic [15:0] EFI_CTL_ADDR = 16'(EFI_CTL_IDX * 4);
    localparam logic [15:0] EFI_FLAGS_ADDR = 16'(EFI_FLAGS_IDX * 4);
    localparam logic [15:0] EFI_ENABLE_ADDR = 16'(EFI_ENABLE_IDX * 4);

    // ==========================================================
    // flag and enable bit positions (same layout in both registers)
    localparam int unsigned EFI_B_CASMF = 7;
    localparam int unsigned EFI_B_NBITS = 6;
    localparam int unsigned EFI_B_SIG = 5;
    localparam int unsigned EFI_B_FASPOS = 4;
    localparam int unsigned EFI_B_OOF = 3;
    localparam int unsigned EFI_B_MIMIC = 2;
    localparam int unsigned EFI_B_CRC4 = 1;
    localparam int unsigned EFI_B_FBIT = 0;

    // ==========================================================
    // framing control fields
    localparam int unsigned EFI_CTL_CASEN = 7;
    localparam int unsigned EFI_CTL_CASLIM_LO = 5;
    localparam int unsigned EFI_CTL_FASLIM_LO = 0;

    // ==========================================================
    // reset values and bus answers
    localparam logic [7:0] EFI_FLAGS_RST = 8'h00;
    localparam logic [7:0] EFI_ENABLE_RST = 8'h00;
    localparam logic [7:0] EFI_CTL_RST = 8'h00;
    localparam logic [1:0] EFI_RESP_OKAY = 2'h0;
    localparam logic [1:0] EFI_RESP_SLVERR = 2'h2;

    // events and samples from the receive framer, same clock as aclk
    typedef struct packed {
        logic cas_word_stb;   // a cas multiframe alignment word was checked
        logic cas_word_err;   // that word was in error
        logic fas_word_stb;   // a fas pattern was checked
        logic fas_word_err;   // that pattern was in error
        logic nonfas_stb;     // national bits of a non-fas frame are valid
        logic [4:0] sa_bits;  // national bits sa4..sa8
        logic sig_change;     // abcd change seen in some signalling channel
        logic fas_pos_change; // fas found at a new bit position
        logic frame_mimic;    // payload imitates the fas pattern
        logic crc4_err;       // crc-4 check failed for a sub-multiframe
        logic fas_bit_err;    // one or more framing bit errors
    } efi_evt_t;

endpackage

// File: rtl/efi_top.sv
// e1 framer event flags, event enables, loss-of-alignment state and irq
// assumes framer event strobes on aclk and an axi4-lite master on aclk
`timescale 1ns/1ps
module efi_top (
    input wire logic aclk,                         // system clock, 10 MHz
    input wire logic aresetn,                      // synchronous reset, active low
    input wire logic [15:0] awaddr,                // write address
    input wire logic awvalid,                      // write address valid
    output logic awready,                          // write address ready
    input wire logic [31:0] wdata,                 // write data
    input wire logic [3:0] wstrb,                  // write byte strobes
    input wire logic wvalid,                       // write data valid
    output logic wready,                           // write data ready
    output logic [1:0] bresp,                      // write response
    output logic bvalid,                           // write response valid
    input wire logic bready,                       // write response ready
    input wire logic [15:0] araddr,                // read address
    input wire logic arvalid,                      // read address valid
    output logic arready,                          // read address ready
    output logic [31:0] rdata,                     // read data
    output logic [1:0] rresp,                      // read response
    output logic rvalid,                           // read data valid
    input wire logic rready,                       // read data ready
    input wire efi_pkg::efi_evt_t evt,             // framer events
    output logic irq,                              // framer interrupt, level
    output logic cas_mf_loss,                      // loss of cas multiframe alignment
    output logic out_of_frame                      // out-of-frame defect
);

    // ==========================================================
    // registers
    logic awready_q, awready_d, wready_q, wready_d;
    logic aw_held_q, aw_held_d, w_held_q, w_held_d;
    logic [15:0] aw_addr_q;
    logic [7:0] w_byte_q;
    logic w_lane_q;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q;
    logic arready_q, arready_d, rvalid_q, rvalid_d;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic [7:0] ctl_q, enable_q, flags_q, flags_d;
    logic [2:0] cas_cnt_q, cas_cnt_d;
    logic [3:0] fas_cnt_q, fas_cnt_d;
    logic cas_loss_q, cas_loss_d, oof_q, oof_d;
    logic [4:0] sa_prev_q;
    logic sa_seen_q;
    logic irq_q, irq_d;

    // ==========================================================
    // bus decode
    logic aw_take, w_take, ar_take, wr_do;
    logic wr_ctl, wr_enable, wr_hit;
    logic rd_ctl, rd_flags, rd_enable, rd_hit, rd_clear;
    logic [7:0] rd_byte;

    assign aw_take = awvalid & awready_q;
    assign w_take = wvalid & wready_q;
    assign ar_take = arvalid & arready_q;
    // a write commits once both halves are held and no response is pending
    assign wr_do = aw_held_q & w_held_q & ~bvalid_q;

    assign wr_ctl = aw_addr_q == efi_pkg::EFI_CTL_ADDR;
    assign wr_enable = aw_addr_q == efi_pkg::EFI_ENABLE_ADDR;
    // flag register is read-to-clear; a write there is accepted and ignored
    assign wr_hit = wr_ctl | wr_enable | (aw_addr_q == efi_pkg::EFI_FLAGS_ADDR);

    assign rd_ctl = araddr == efi_pkg::EFI_CTL_ADDR;
    assign rd_flags = araddr == efi_pkg::EFI_FLAGS_ADDR;
    assign rd_enable = araddr == efi_pkg::EFI_ENABLE_ADDR;
    assign rd_hit = rd_ctl | rd_flags | rd_enable;
    assign rd_clear = ar_take & rd_flags;
    assign rd_byte = rd_flags ? flags_q :
                     rd_enable ? enable_q :
                     rd_ctl ? ctl_q : 8'h00;

    assign aw_held_d = (aw_held_q | aw_take) & ~wr_do;
    assign w_held_d = (w_held_q | w_take) & ~wr_do;
    assign awready_d = ~aw_held_d;
    assign wready_d = ~w_held_d;
    assign bvalid_d = wr_do | (bvalid_q & ~bready);
    assign rvalid_d = ar_take | (rvalid_q & ~rready);
    // one read at a time: the next address waits for the data to be taken
    assign arready_d = ~rvalid_d;

    // ==========================================================
    // write channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            bvalid_q <= 1'b0;
        end else begin
            awready_q <= awready_d;
            wready_q <= wready_d;
            aw_held_q <= aw_held_d;
            w_held_q <= w_held_d;
            bvalid_q <= bvalid_d;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr_q <= 16'h0000;
            w_byte_q <= 8'h00;
            w_lane_q <= 1'b0;
            bresp_q <= efi_pkg::EFI_RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_addr_q <= awaddr;
            end
            if (w_take) begin
                w_byte_q <= wdata[7:0];
                w_lane_q <= wstrb[0];
            end
            if (wr_do) begin
                bresp_q <= wr_hit ? efi_pkg::EFI_RESP_OKAY : efi_pkg::EFI_RESP_SLVERR;
            end
        end
    end

    // ==========================================================
    // control registers
    logic [7:0] enable_d;

    // irq looks at the next mask so it never lags a mask write by a cycle
    assign enable_d = (wr_do & wr_enable & w_lane_q) ? w_byte_q : enable_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl_q <= efi_pkg::EFI_CTL_RST;
            enable_q <= efi_pkg::EFI_ENABLE_RST;
        end else begin
            if (wr_do & wr_ctl & w_lane_q) begin
                ctl_q <= w_byte_q;
            end
            enable_q <= enable_d;
        end
    end

    // ==========================================================
    // read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= efi_pkg::EFI_RESP_OKAY;
        end else begin
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            if (ar_take) begin
                rdata_q <= {24'h000000, rd_byte};
                rresp_q <= rd_hit ? efi_pkg::EFI_RESP_OKAY : efi_pkg::EFI_RESP_SLVERR;
            end
        end
    end

    // ==========================================================
    // alignment loss detectors
    logic cas_en;
    logic [2:0] cas_limit, cas_inc;
    logic [3:0] fas_limit, fas_inc;

    assign cas_en = ctl_q[efi_pkg::EFI_CTL_CASEN];
    // criterion field n means n+1 consecutive errored words
    assign cas_limit = {1'b0, ctl_q[efi_pkg::EFI_CTL_CASLIM_LO +: 2]} + 3'h1;
    assign fas_limit = {1'b0, ctl_q[efi_pkg::EFI_CTL_FASLIM_LO +: 3]} + 4'h1;
    // counters saturate at the limit so a long error run cannot wrap
    assign cas_inc = (cas_cnt_q >= cas_limit) ? cas_limit : cas_cnt_q + 3'h1;
    assign fas_inc = (fas_cnt_q >= fas_limit) ? fas_limit : fas_cnt_q + 4'h1;

    always_comb begin
        cas_cnt_d = cas_cnt_q;
        cas_loss_d = cas_loss_q;
        if (!cas_en) begin
            cas_cnt_d = 3'h0;
            cas_loss_d = 1'b0;
        end else if (evt.cas_word_stb && evt.cas_word_err) begin
            cas_cnt_d = cas_inc;
            cas_loss_d = cas_loss_q | (cas_inc >= cas_limit);
        end else if (evt.cas_word_stb) begin
            cas_cnt_d = 3'h0;
            cas_loss_d = 1'b0;
        end
    end

    // framing bit errors alone do not move this state machine
    always_comb begin
        fas_cnt_d = fas_cnt_q;
        oof_d = oof_q;
        if (evt.fas_word_stb && evt.fas_word_err) begin
            fas_cnt_d = fas_inc;
            oof_d = oof_q | (fas_inc >= fas_limit);
        end else if (evt.fas_word_stb) begin
            fas_cnt_d = 4'h0;
            oof_d = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cas_cnt_q <= 3'h0;
            cas_loss_q <= 1'b0;
            fas_cnt_q <= 4'h0;
            oof_q <= 1'b0;
            sa_prev_q <= 5'h00;
            sa_seen_q <= 1'b0;
        end else begin
            cas_cnt_q <= cas_cnt_d;
            cas_loss_q <= cas_loss_d;
            fas_cnt_q <= fas_cnt_d;
            oof_q <= oof_d;
            if (evt.nonfas_stb) begin
                sa_prev_q <= evt.sa_bits;
                sa_seen_q <= 1'b1;
            end
        end
    end

    // ==========================================================
    // event flags
    logic [7:0] set_vec;

    // the first non-fas frame after reset only loads the reference bits
    assign set_vec[efi_pkg::EFI_B_CASMF] = cas_en & (cas_loss_d ^ cas_loss_q);
    assign set_vec[efi_pkg::EFI_B_NBITS] = evt.nonfas_stb & sa_seen_q &
                                           (evt.sa_bits != sa_prev_q);
    assign set_vec[efi_pkg::EFI_B_SIG] = cas_en & evt.sig_change;
    assign set_vec[efi_pkg::EFI_B_FASPOS] = evt.fas_pos_change;
    assign set_vec[efi_pkg::EFI_B_OOF] = oof_d ^ oof_q;
    assign set_vec[efi_pkg::EFI_B_MIMIC] = evt.frame_mimic;
    assign set_vec[efi_pkg::EFI_B_CRC4] = evt.crc4_err;
    assign set_vec[efi_pkg::EFI_B_FBIT] = evt.fas_bit_err;

    // a set in the cycle of the clearing read wins, so no event is lost
    for (genvar i = 0; i < 8; i++) begin : g_flag
        assign flags_d[i] = (flags_q[i] & ~rd_clear) | set_vec[i];
    end

    assign irq_d = |(flags_d & enable_d);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_q <= efi_pkg::EFI_FLAGS_RST;
            irq_q <= 1'b0;
        end else begin
            flags_q <= flags_d;
            irq_q <= irq_d;
        end
    end

    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign irq = irq_q;
    assign cas_mf_loss = cas_loss_q;
    assign out_of_frame = oof_q;

    // ==========================================================
    // assertions
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence fas_err_s;
        evt.fas_word_stb && evt.fas_word_err;
    endsequence

    sequence fas_last_err_s;
        fas_err_s and (fas_inc >= fas_limit);
    endsequence

    sequence cas_last_err_s;
        cas_en && evt.cas_word_stb && evt.cas_word_err && (cas_inc >= cas_limit);
    endsequence

    sequence quiet_read_s;
        rd_clear && (set_vec == 8'h00);
    endsequence

    cas_loss_decl_a: assert property (cas_last_err_s |=> cas_mf_loss)
        else $error("cas loss not declared at criterion");
    cas_flag_a: assert property ($changed(cas_mf_loss) && cas_en |-> flags_q[7])
        else $error("cas loss change did not set flag");
    nbits_flag_a: assert property (
        evt.nonfas_stb && sa_seen_q && evt.sa_bits != sa_prev_q |=> flags_q[6])
        else $error("national bit change did not set flag");
    sig_gate_a: assert property (
        !cas_en && !flags_q[5] && !rd_clear |=> !flags_q[5] || $past(cas_en))
        else $error("signalling flag set while cas disabled");
    faspos_flag_a: assert property (evt.fas_pos_change |=> flags_q[4])
        else $error("fas position change lost");
    oof_decl_a: assert property (fas_last_err_s |=> out_of_frame ##0 flags_q[3] || $past(oof_q))
        else $error("out of frame not declared at criterion");
    oof_flag_a: assert property ($changed(out_of_frame) |-> flags_q[3])
        else $error("out of frame change did not set flag");
    mimic_flag_a: assert property (evt.frame_mimic |=> flags_q[2])
        else $error("frame mimic lost");
    crc_flag_a: assert property (evt.crc4_err |=> flags_q[1])
        else $error("crc-4 error lost");
    fbit_nosync_a: assert property (evt.fas_bit_err && !evt.fas_word_stb |=> $stable(oof_q))
        else $error("framing bit error moved out of frame state");
    read_clear_a: assert property (quiet_read_s |=> flags_q == 8'h00 && !irq)
        else $error("flags not cleared by read");
    enable_rst_a: assert property (@(posedge aclk) disable iff (1'b0)
        !aresetn |=> enable_q == 8'h00)
        else $error("enable register not cleared by reset");
    irq_level_a: assert property (irq == |(flags_q & enable_q))
        else $error("irq disagrees with flags and enables");

    // ==========================================================
    // bus answers, sticky flags and alignment recovery
    sequence good_cas_s;
        evt.cas_word_stb && !evt.cas_word_err;
    endsequence

    sequence good_fas_s;
        evt.fas_word_stb && !evt.fas_word_err;
    endsequence

    sequence enable_wr_s;
        wr_do && wr_enable && w_lane_q;
    endsequence

    wr_answer_a: assert property (wr_do |=> bvalid)
        else $error("write not answered one cycle after commit");
    rd_answer_a: assert property (ar_take |=> rvalid)
        else $error("read not answered one cycle after the address");
    rd_single_a: assert property (rvalid |-> !arready)
        else $error("read address accepted while read data pending");
    enable_write_a: assert property (enable_wr_s |=> enable_q == $past(w_byte_q))
        else $error("enable register did not take the written byte");
    flag_sticky_a: assert property (!rd_clear |=>
        (flags_q & $past(flags_q)) == $past(flags_q))
        else $error("a flag dropped without a read");
    rd_snapshot_a: assert property (rd_clear |=> rdata[7:0] == $past(flags_q))
        else $error("flag read did not return the flags before the clear");
    sig_flag_a: assert property (cas_en && evt.sig_change |=> flags_q[5])
        else $error("signalling change lost");
    fbit_flag_a: assert property (evt.fas_bit_err |=> flags_q[0])
        else $error("framing bit error lost");
    cas_off_a: assert property (!cas_en |=> !cas_mf_loss)
        else $error("cas loss held while cas disabled");
    cas_good_a: assert property (good_cas_s |=> !cas_mf_loss)
        else $error("good cas word did not clear the loss");
    oof_good_a: assert property (good_fas_s |=> !out_of_frame)
        else $error("good fas pattern did not clear out of frame");

endmodule

// File: verification/efi_top_tb.sv
// self-checking bench for the framer event flags, enables and interrupt
// assumes efi_top as the only design module; the bench is the axi4-lite master
`timescale 1ns/1ps
module efi_top_tb;
    localparam logic [1:0] OK = efi_pkg::EFI_RESP_OKAY;
    localparam logic [1:0] ERR = efi_pkg::EFI_RESP_SLVERR;
    localparam logic [15:0] FLG = efi_pkg::EFI_FLAGS_ADDR;
    localparam logic [15:0] ENA = efi_pkg::EFI_ENABLE_ADDR;
    localparam logic [15:0] CTL = efi_pkg::EFI_CTL_ADDR;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [15:0] awaddr = 16'h0000;
    logic awvalid = 1'b0;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0] wstrb = 4'hF;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic [15:0] araddr = 16'h0000;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    efi_pkg::efi_evt_t evt = '0;
    logic awready, wready, bvalid, arready, rvalid, irq, cas_mf_loss, out_of_frame;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [31:0] seed = 32'hC29939CE;
    int errors = 0;
    int total_checks = 0;

    always #50 aclk = ~aclk;

    efi_top i_efi_top (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .evt(evt), .irq(irq), .cas_mf_loss(cas_mf_loss), .out_of_frame(out_of_frame));

    // ==========================================================
    // expectation helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [31:0] exp_irq(input logic [7:0] f, input logic [7:0] e);
        return {31'h0, |(f & e)};
    endfunction

    function automatic efi_pkg::efi_evt_t mk(input logic [7:0] m);
        efi_pkg::efi_evt_t e;
        e = '0;
        e.sig_change = m[5];
        e.fas_pos_change = m[4];
        e.frame_mimic = m[2];
        e.crc4_err = m[1];
        e.fas_bit_err = m[0];
        return e;
    endfunction

    // ==========================================================
    // reporting
    task automatic print_verdict;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // ==========================================================
    // bus cycles; waits are bounded so a dead slave ends the run
    task automatic wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        r = 2'h3;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
        if (n == 50) begin
            errors++;
            print_verdict();
        end
    endtask

    task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        d = 32'h0;
        r = 2'h3;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
        if (n == 50) begin
            errors++;
            print_verdict();
        end
    endtask

    task automatic wr_chk(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [1:0] r;
        wr(a, d, r);
        chk({30'h0, r}, {30'h0, er});
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [31:0] e, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(d, e);
        chk({30'h0, r}, {30'h0, er});
    endtask

    // one-cycle event strobe, returns where outputs have settled
    task automatic pulse(input efi_pkg::efi_evt_t e);
        @(posedge aclk);
        evt <= e;
        @(posedge aclk);
        evt <= '0;
        @(negedge aclk);
    endtask

    // errored words up to the criterion, then one good word clears the loss
    task automatic loss_run(input bit cas, input int lim, input logic [7:0] fb);
        efi_pkg::efi_evt_t e;
        int k;
        e = '0;
        e.cas_word_stb = cas;
        e.cas_word_err = cas;
        e.fas_word_stb = !cas;
        e.fas_word_err = !cas;
        for (k = 0; k <= lim; k++) begin
            pulse(e);
            chk({31'h0, cas ? cas_mf_loss : out_of_frame}, {31'h0, k == lim});
        end
        rd_chk(FLG, {24'h0, fb}, OK);
        e.cas_word_err = 1'b0;
        e.fas_word_err = 1'b0;
        pulse(e);
        chk({31'h0, cas ? cas_mf_loss : out_of_frame}, 32'h0);
        rd_chk(FLG, {24'h0, fb}, OK);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        efi_pkg::efi_evt_t e;
        logic [7:0] m, en;
        int i;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd_chk(ENA, 32'h0, OK);
        rd_chk(FLG, 32'h0, OK);
        chk({31'h0, irq}, 32'h0);
        e = '0;
        e.nonfas_stb = 1'b1;
        e.sa_bits = 5'h0A;
        pulse(e);
        pulse(e);
        rd_chk(FLG, 32'h0, OK);
        e.sa_bits = 5'h0B;
        pulse(e);
        rd_chk(FLG, 32'h40, OK);
        // cas disabled: signalling and cas alignment must stay silent
        wr_chk(CTL, 32'h0, OK);
        e = mk(8'h20);
        e.cas_word_stb = 1'b1;
        e.cas_word_err = 1'b1;
        pulse(e);
        chk({31'h0, cas_mf_loss}, 32'h0);
        rd_chk(FLG, 32'h0, OK);
        wr_chk(16'h0008, 32'hFF, ERR);
        rd_chk(16'h0004, 32'h0, ERR);
        pulse(mk(8'h01));
        wr_chk(FLG, 32'h0, OK);
        rd_chk(FLG, 32'h01, OK);
        seed = lfsr(seed);
        wr_chk(CTL, {24'h0, 1'b1, seed[6:5], 2'b00, seed[2:0]}, OK);
        rd_chk(CTL, {24'h0, 1'b1, seed[6:5], 2'b00, seed[2:0]}, OK);
        loss_run(1'b1, int'(seed[6:5]), 8'h80);
        loss_run(1'b0, int'(seed[2:0]), 8'h08);
        for (i = 0; i < 24; i++) begin
            seed = lfsr(seed);
            en = (i == 0) ? 8'hFF : seed[7:0];
            m = (i == 0) ? 8'h37 : (seed[15:8] & 8'h37);
            wr_chk(ENA, {seed[31:8], en}, OK);
            rd_chk(ENA, {24'h0, en}, OK);
            pulse(mk(m));
            chk({31'h0, irq}, exp_irq(m, en));
            rd_chk(FLG, {24'h0, m}, OK);
            @(negedge aclk);
            chk({31'h0, irq}, 32'h0);
            rd_chk(FLG, 32'h0, OK);
        end
        // a cleared byte lane leaves the mask alone
        wstrb <= 4'h0;
        wr_chk(ENA, {24'h0, ~en}, OK);
        wstrb <= 4'hF;
        rd_chk(ENA, {24'h0, en}, OK);
        // reset in mid-run with flags, mask and control register all non-zero
        pulse(mk(8'h37));
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(ENA, 32'h0, OK);
        rd_chk(FLG, 32'h0, OK);
        rd_chk(CTL, 32'h0, OK);
        @(negedge aclk);
        chk({31'h0, irq}, 32'h0);
        print_verdict();
    end
endmodule
